// file: hdl/mc_ingress_pkg.sv
package mc_ingress_pkg;

   // ==========================================================
   // register map, byte addresses on the AXI4-Lite slave
   localparam logic [7:0] OFF_CAP        = 8'h00;
   localparam logic [7:0] OFF_CTL        = 8'h04;
   localparam logic [7:0] OFF_BASE_LO    = 8'h08;
   localparam logic [7:0] OFF_BASE_HI    = 8'h0C;
   localparam logic [7:0] OFF_BLKALL_LO  = 8'h10;
   localparam logic [7:0] OFF_BLKALL_HI  = 8'h14;
   localparam logic [7:0] OFF_BLKUT_LO   = 8'h18;
   localparam logic [7:0] OFF_BLKUT_HI   = 8'h1C;
   localparam logic [7:0] OFF_STATUS     = 8'h20;
   localparam logic [7:0] OFF_BLK_COUNT  = 8'h24;

   // ==========================================================
   // field positions and reset values
   localparam int         CTL_EN_BIT     = 31;
   localparam int         BASE_LO_LSB    = 6;
   localparam int         STS_PRI_BIT    = 0;
   localparam int         STS_SEC_BIT    = 1;
   localparam logic [5:0] MAX_GROUP_RST  = 6'h1F;  // field holds count minus one
   localparam logic [1:0] AT_UNTRANSLATED = 2'h0;
   localparam logic [1:0] RESP_OKAY      = 2'h0;
   localparam logic [1:0] RESP_SLVERR    = 2'h2;

   // ==========================================================
   // packet header carried alongside the classification
   typedef enum logic [1:0] {
      PKT_MEMWR    = 2'h0,   // posted memory write
      PKT_MSG_ADDR = 2'h1,   // address-routed message
      PKT_OTHER    = 2'h3
   } pkt_kind_t;

   typedef struct packed {
      pkt_kind_t   kind;
      logic [63:0] addr;
      logic [1:0]  addrType;
      logic        poisoned;
      logic        malformed;
      logic        ecrcBad;
      logic        acsSrcFail;
   } pkt_hdr_t;

   typedef struct packed {
      pkt_hdr_t   hdr;
      logic       isMc;
      logic [5:0] groupId;
      logic       blocked;
      logic       acsFail;
      logic       silentDrop;
   } class_res_t;

   // number of group-ID address bits: ceil(log2(count + 1))
   function automatic logic [2:0] gid_width(input logic [5:0] count);
      logic [6:0] n;
      n = {1'b0, count};
      gid_width = 3'h0;
      for (int i = 0; i < 7; i++) begin
         if (n > (7'h1 << i) - 7'h1) begin
            gid_width = 3'(i + 1);
         end
      end
   endfunction : gid_width

endpackage : mc_ingress_pkg

// file: hdl/mc_address_match.sv
`timescale 1ns/1ps

// ==========================================================
// address match and group-ID extraction, purely combinational
module mc_address_match
   import mc_ingress_pkg::*;
(
   input  wire logic [63:0] addr,
   input  wire logic [63:0] base,
   input  wire logic [5:0]  exponent,
   input  wire logic [5:0]  enabledCount,
   output logic             baseHit,
   output logic [5:0]       groupId
);

   logic [2:0]  gidBits;
   logic [63:0] lowMask;
   logic [63:0] gidMask;
   logic [63:0] shifted;

   // region size is 2**exponent, group n sits n regions above base
   always_comb begin
      gidBits = gid_width(enabledCount);
      lowMask = (64'h1 << exponent) - 64'h1;
      gidMask = ((64'h1 << gidBits) - 64'h1) << exponent;
      shifted = (addr >> exponent) & ((64'h1 << gidBits) - 64'h1);
      groupId = shifted[5:0];
      // base must already hold zeros in the masked bits
      baseHit = ((addr & ~(lowMask | gidMask)) == base);
   end

endmodule : mc_address_match

// file: hdl/multicast_ingress_classifier.sv
`timescale 1ns/1ps

// How it works
// - up to 64 groups; capability field resets to 32 groups, software may raise it.
// - only posted memory writes and address-routed messages can be multicast.
// - enable clear means nothing is multicast; non-multicast goes the unicast way.
// - group regions stack upward from group zero, one per enabled group.
// - each region spans two to the power of the size exponent bytes.
// - base address is 64 bits built from the low and high base fields.
// - group n starts at base plus n regions.
// - mask low and group-ID bits, compare with base; mismatch means unicast.
// - group ID is ceil(log2(count+1)) bits starting at the exponent position.
// - group ID above the enabled count means not multicast.
// - multicast packets get only the source-validation access check.
// - block-all bit of the packet's group blocks it.
// - block-untranslated bit blocks it when the address type says untranslated.
// - blocked packets are dropped and their credits returned.
// - blocked packets raise an error report with the header logged.
// - blocked packet sets target-abort flag, primary if upstream, else secondary.
// - both block filters are applied at the receiving port.
// - multicast keeps posted ordering, nothing extra.
// - malformed, poison and CRC handling stay as for any packet.
// - multicast stays within the receiving partition.
// - multicast accepted by no function is dropped silently.
module multicast_ingress_classifier
   import mc_ingress_pkg::*;
(
   input  wire logic                     clk_sys,
   input  wire logic                     rst_n,
   // axi4-lite slave
   input  wire logic [7:0]               s_axi_awaddr,
   input  wire logic                     s_axi_awvalid,
   output logic                          s_axi_awready,
   input  wire logic [31:0]              s_axi_wdata,
   input  wire logic [3:0]               s_axi_wstrb,
   input  wire logic                     s_axi_wvalid,
   output logic                          s_axi_wready,
   output logic [1:0]                    s_axi_bresp,
   output logic                          s_axi_bvalid,
   input  wire logic                     s_axi_bready,
   input  wire logic [7:0]               s_axi_araddr,
   input  wire logic                     s_axi_arvalid,
   output logic                          s_axi_arready,
   output logic [31:0]                   s_axi_rdata,
   output logic [1:0]                    s_axi_rresp,
   output logic                          s_axi_rvalid,
   input  wire logic                     s_axi_rready,
   // port role and egress acceptance
   input  wire logic                     isUpstream,
   input  wire logic [63:0]              recvUnion,
   // ingress packet
   input  wire logic                     pktValid,
   input  wire mc_ingress_pkg::pkt_hdr_t pktHdr,
   // classification result
   output logic                          resValid,
   output mc_ingress_pkg::class_res_t    res,
   output logic                          mcDrop,
   output logic                          creditReturn,
   output logic                          aerMcBlocked,
   output mc_ingress_pkg::pkt_hdr_t      aerHdrLog,
   output logic                          staPrimary,
   output logic                          staSecondary
);

   // ==========================================================
   // state of the block
   typedef struct packed {
      logic        awGot;
      logic [7:0]  awAddr;
      logic        wGot;
      logic [31:0] wData;
      logic [3:0]  wStrb;
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic [5:0]  max_group_count;
      logic        mcEnable;
      logic [5:0]  enabledCount;
      logic [5:0]  exponent;
      logic [63:0] base;
      logic [63:0] blockAll;
      logic [63:0] blockUt;
      logic        staPri;
      logic        staSec;
      logic [15:0] blockCount;
      logic        resValid;
      class_res_t  res;
      logic        drop;
      logic        credit;
      logic        aer;
      pkt_hdr_t    aerHdr;
   } state_t;

   state_t      state_ff;
   state_t      nxt_state;
   logic [1:0]  rstPipe_ff;
   logic        rstSyncN;
   logic        baseHit;
   logic [5:0]  gid;
   logic        candidate;
   logic        mcHit;
   logic        blockedNow;
   logic [31:0] rdWord;
   logic [31:0] mergeTmp;   // old word with the written bytes laid in, sliced afterwards

   // ==========================================================
   // reset release through two flops
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rstPipe_ff <= 2'h0;
      end else begin
         rstPipe_ff <= {rstPipe_ff[0], 1'b1};
      end
   end
   assign rstSyncN = rstPipe_ff[1];

   // ==========================================================
   // byte-lane merge for register writes
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] dat,
                                         input logic [3:0]  strb);
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            old[8*i +: 8] = dat[8*i +: 8];
         end
      end
      merge = old;
   endfunction : merge

   function automatic logic mapped(input logic [7:0] off);
      mapped = (off[1:0] == 2'h0) && (off <= OFF_BLK_COUNT);
   endfunction : mapped

   // ==========================================================
   // address compare, shared by every packet
   mc_address_match u_match (
      .addr         (pktHdr.addr),
      .base         (state_ff.base),
      .exponent     (state_ff.exponent),
      .enabledCount (state_ff.enabledCount),
      .baseHit      (baseHit),
      .groupId      (gid)
   );

   // classification of the packet on the input this cycle
   always_comb begin
      candidate  = pktValid && ((pktHdr.kind == PKT_MEMWR) ||
                                (pktHdr.kind == PKT_MSG_ADDR));
      mcHit      = candidate && state_ff.mcEnable && baseHit &&
                   (gid <= state_ff.enabledCount);
      // filters use this ingress port's own vectors
      blockedNow = mcHit && (state_ff.blockAll[gid] ||
                   (state_ff.blockUt[gid] &&
                    (pktHdr.addrType == AT_UNTRANSLATED)));
   end

   // ==========================================================
   // register read decode
   always_comb begin
      rdWord = 32'h0;
      unique case (s_axi_araddr)
         OFF_CAP:       rdWord = {26'h0, state_ff.max_group_count};
         OFF_CTL:       rdWord = {state_ff.mcEnable, 25'h0,
                                  state_ff.enabledCount};
         OFF_BASE_LO:   rdWord = {state_ff.base[31:BASE_LO_LSB],
                                  state_ff.exponent};
         OFF_BASE_HI:   rdWord = state_ff.base[63:32];
         OFF_BLKALL_LO: rdWord = state_ff.blockAll[31:0];
         OFF_BLKALL_HI: rdWord = state_ff.blockAll[63:32];
         OFF_BLKUT_LO:  rdWord = state_ff.blockUt[31:0];
         OFF_BLKUT_HI:  rdWord = state_ff.blockUt[63:32];
         OFF_STATUS:    rdWord = {30'h0, state_ff.staSec, state_ff.staPri};
         OFF_BLK_COUNT: rdWord = {16'h0, state_ff.blockCount};
         default:       rdWord = 32'h0;
      endcase
   end

   // ==========================================================
   // next state: bus slave, registers, packet pipeline
   always_comb begin
      nxt_state = state_ff;
      mergeTmp  = 32'h0;

      // write address and data are taken in either order
      if (s_axi_awvalid && state_ff.awready) begin
         nxt_state.awGot  = 1'b1;
         nxt_state.awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && state_ff.wready) begin
         nxt_state.wGot  = 1'b1;
         nxt_state.wData = s_axi_wdata;
         nxt_state.wStrb = s_axi_wstrb;
      end
      if (state_ff.bvalid && s_axi_bready) begin
         nxt_state.bvalid = 1'b0;
      end

      // perform the write once both halves are in
      if (nxt_state.awGot && nxt_state.wGot && !nxt_state.bvalid) begin
         nxt_state.awGot  = 1'b0;
         nxt_state.wGot   = 1'b0;
         nxt_state.bvalid = 1'b1;
         nxt_state.bresp  = mapped(nxt_state.awAddr) ? RESP_OKAY : RESP_SLVERR;
         unique case (nxt_state.awAddr)
            OFF_CAP: begin
               mergeTmp           = merge({26'h0, state_ff.max_group_count},
                                          nxt_state.wData, nxt_state.wStrb);
               nxt_state.max_group_count = mergeTmp[5:0];
            end
            OFF_CTL: begin
               mergeTmp = merge({state_ff.mcEnable, 25'h0, state_ff.enabledCount},
                                nxt_state.wData, nxt_state.wStrb);
               nxt_state.mcEnable     = mergeTmp[CTL_EN_BIT];
               nxt_state.enabledCount = mergeTmp[5:0];
            end
            OFF_BASE_LO: begin
               {nxt_state.base[31:BASE_LO_LSB], nxt_state.exponent} =
                  merge({state_ff.base[31:BASE_LO_LSB], state_ff.exponent},
                        nxt_state.wData, nxt_state.wStrb);
            end
            OFF_BASE_HI: begin
               nxt_state.base[63:32] = merge(state_ff.base[63:32],
                                             nxt_state.wData, nxt_state.wStrb);
            end
            OFF_BLKALL_LO: begin
               nxt_state.blockAll[31:0] = merge(state_ff.blockAll[31:0],
                                                nxt_state.wData, nxt_state.wStrb);
            end
            OFF_BLKALL_HI: begin
               nxt_state.blockAll[63:32] = merge(state_ff.blockAll[63:32],
                                                 nxt_state.wData, nxt_state.wStrb);
            end
            OFF_BLKUT_LO: begin
               nxt_state.blockUt[31:0] = merge(state_ff.blockUt[31:0],
                                               nxt_state.wData, nxt_state.wStrb);
            end
            OFF_BLKUT_HI: begin
               nxt_state.blockUt[63:32] = merge(state_ff.blockUt[63:32],
                                                nxt_state.wData, nxt_state.wStrb);
            end
            OFF_STATUS: begin
               // write one to clear; a same-cycle event sets it again below
               if (nxt_state.wStrb[0] && nxt_state.wData[STS_PRI_BIT]) begin
                  nxt_state.staPri = 1'b0;
               end
               if (nxt_state.wStrb[0] && nxt_state.wData[STS_SEC_BIT]) begin
                  nxt_state.staSec = 1'b0;
               end
            end
            default: begin
               nxt_state.bresp = nxt_state.bresp;
            end
         endcase
      end
      nxt_state.awready = !nxt_state.awGot && !nxt_state.bvalid;
      nxt_state.wready  = !nxt_state.wGot && !nxt_state.bvalid;

      // read channel: one read under way at a time
      if (state_ff.rvalid && s_axi_rready) begin
         nxt_state.rvalid = 1'b0;
      end
      if (s_axi_arvalid && state_ff.arready) begin
         nxt_state.rvalid = 1'b1;
         nxt_state.rdata  = rdWord;
         nxt_state.rresp  = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end
      nxt_state.arready = !nxt_state.rvalid;

      // one-stage pipeline keeps packets in arrival order
      nxt_state.resValid       = pktValid;
      nxt_state.res.hdr        = pktHdr;
      nxt_state.res.isMc       = mcHit;
      nxt_state.res.groupId    = mcHit ? gid : 6'h0;
      nxt_state.res.blocked    = blockedNow;
      nxt_state.res.acsFail    = mcHit && pktHdr.acsSrcFail;
      nxt_state.res.silentDrop = mcHit && !blockedNow && !recvUnion[gid];
      nxt_state.drop           = blockedNow;
      nxt_state.credit         = blockedNow;
      nxt_state.aer            = blockedNow;
      if (blockedNow) begin
         nxt_state.aerHdr     = pktHdr;
         nxt_state.blockCount = state_ff.blockCount + 16'h1;
         // the event wins over a clear in the same cycle
         if (isUpstream) begin
            nxt_state.staPri = 1'b1;
         end else begin
            nxt_state.staSec = 1'b1;
         end
      end
   end

   // ==========================================================
   // single state register
   always_ff @(posedge clk_sys or negedge rstSyncN) begin
      if (!rstSyncN) begin
         state_ff          <= '0;
         state_ff.max_group_count <= MAX_GROUP_RST;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // outputs come straight from the state register
   assign s_axi_awready = state_ff.awready;
   assign s_axi_wready  = state_ff.wready;
   assign s_axi_bvalid  = state_ff.bvalid;
   assign s_axi_bresp   = state_ff.bresp;
   assign s_axi_arready = state_ff.arready;
   assign s_axi_rvalid  = state_ff.rvalid;
   assign s_axi_rdata   = state_ff.rdata;
   assign s_axi_rresp   = state_ff.rresp;
   assign resValid      = state_ff.resValid;
   assign res           = state_ff.res;
   assign mcDrop        = state_ff.drop;
   assign creditReturn  = state_ff.credit;
   assign aerMcBlocked  = state_ff.aer;
   assign aerHdrLog     = state_ff.aerHdr;
   assign staPrimary    = state_ff.staPri;
   assign staSecondary  = state_ff.staSec;

   // ==========================================================
   // checks
   a_disabled_no_mc: assert property (@(posedge clk_sys) disable iff (!rstSyncN)
      pktValid && !state_ff.mcEnable |=> !res.isMc)
      else $error("multicast flagged while disabled");

   a_kind_filter: assert property (@(posedge clk_sys) disable iff (!rstSyncN)
      pktValid && (pktHdr.kind == PKT_OTHER) |=> !res.isMc && !res.blocked)
      else $error("non-posted kind classified multicast");

   a_gid_in_range: assert property (@(posedge clk_sys) disable iff (!rstSyncN)
      resValid && res.isMc |-> res.groupId <= $past(state_ff.enabledCount))
      else $error("group id beyond enabled count");

   a_block_all_hit: assert property (@(posedge clk_sys) disable iff (!rstSyncN)
      mcHit && state_ff.blockAll[gid] |=> resValid && res.blocked)
      else $error("block-all bit did not block");

   a_block_ut_hit: assert property (@(posedge clk_sys) disable iff (!rstSyncN)
      mcHit && state_ff.blockUt[gid] && (pktHdr.addrType != AT_UNTRANSLATED)
      && !state_ff.blockAll[gid] |=> !res.blocked)
      else $error("translated packet blocked by untranslated filter");

   a_drop_credit: assert property (@(posedge clk_sys) disable iff (!rstSyncN)
      resValid && res.blocked |-> mcDrop && creditReturn && aerMcBlocked)
      else $error("blocked packet not dropped with credits");

   a_aer_header: assert property (@(posedge clk_sys) disable iff (!rstSyncN)
      aerMcBlocked |-> (aerHdrLog == res.hdr) && res.isMc)
      else $error("logged header differs from blocked packet");

   a_sta_side: assert property (@(posedge clk_sys) disable iff (!rstSyncN)
      aerMcBlocked |-> ($past(isUpstream) ? staPrimary : staSecondary))
      else $error("target abort flag not set on the right side");

   a_one_cycle: assert property (@(posedge clk_sys) disable iff (!rstSyncN)
      pktValid ##1 !pktValid |-> resValid ##1 !resValid)
      else $error("result not one cycle after the packet");

endmodule : multicast_ingress_classifier

// file: dv/mc_link_source.sv
`timescale 1ns/1ps

// ==========================================
// posted packet source at the far end of the ingress link
module mc_link_source (
   input  wire logic                clk_sys,
   output logic                     pktValid,
   output mc_ingress_pkg::pkt_hdr_t pktHdr
);
   import mc_ingress_pkg::*;

   // idle: no strobe, header bus deliberately scrambled
   initial begin
      pktValid = 1'b0;
      pktHdr   = '1;
   end

   // one header per strobe; the header is inverted afterwards so stale data never matches
   task automatic send(input pkt_hdr_t h);
      @(posedge clk_sys);
      pktValid <= 1'b1;
      pktHdr   <= h;
      @(posedge clk_sys);
      pktValid <= 1'b0;
      pktHdr   <= ~h;
   endtask : send
endmodule : mc_link_source

// file: dv/multicast_ingress_classifier_bench.sv
`timescale 1ns/1ps

// ==========================================
// bench top: register setup over axi4-lite, packets from the link source
module multicast_ingress_classifier_bench;
   import mc_ingress_pkg::*;
   logic        clk_sys, rst_n, isUpstream, resValid, mcDrop, creditReturn;
   logic        aerMcBlocked, staPrimary, staSecondary, pktValid;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [63:0] recvUnion;
   pkt_hdr_t    pktHdr, aerHdrLog, lastHdr;
   class_res_t  res;
   int          bad_count, checks_done;

   mc_link_source src (.clk_sys, .pktValid, .pktHdr);
   multicast_ingress_classifier uut (.clk_sys, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .isUpstream, .recvUnion,
      .pktValid, .pktHdr, .resValid, .res, .mcDrop, .creditReturn, .aerMcBlocked, .aerHdrLog,
      .staPrimary, .staSecondary);

   // ==========================================
   // clock and watchdog; the whole run needs well under 2000 cycles
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   initial begin
      #100us;
      bad_count++;
      finish_test();
   end

   // ==========================================
   // shared tasks
   task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // write: both halves offered together, each dropped once taken, bready held until bvalid
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw, w;
      aw = 1'b1;
      w = 1'b1;
      @(posedge clk_sys);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      while (s_axi_bvalid !== 1'b1) begin
         @(posedge clk_sys);
         if (aw && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (aw && s_axi_awready === 1'b1) aw = 1'b0;
         if (w && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
         if (w && s_axi_wready === 1'b1) w = 1'b0;
      end
      s_axi_bready <= 1'b0;
      chk(s_axi_bresp, er);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge clk_sys);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      while (s_axi_rvalid !== 1'b1) begin
         @(posedge clk_sys);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata, ed);
      chk(s_axi_rresp, er);
   endtask : rd

   // address inside group g: base 0x1_0010_0000, regions of 4 KiB
   function automatic logic [63:0] ga(input int g);
      return 64'h0000_0001_0010_0040 + (64'(g) << 12);
   endfunction : ga

   // one packet; result must come exactly one cycle after the strobe
   task automatic pkt(input pkt_kind_t k, input logic [63:0] a, input logic [1:0] at,
                      input logic mc, input logic [5:0] g, input logic blk);
      lastHdr = '0;
      lastHdr.kind = k;
      lastHdr.addr = a;
      lastHdr.addrType = at;
      src.send(lastHdr);
      #1;
      chk(resValid, 1'b1);
      chk(res.hdr, lastHdr);
      chk(res.isMc, mc);
      chk(res.groupId, g);
      chk(res.blocked, blk);
      chk({mcDrop, creditReturn, aerMcBlocked}, {3{blk}});
   endtask : pkt

   task automatic finish_test();
      $display("checks_done %0d bad_count %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : finish_test

   // ==========================================
   // main sequence
   initial begin
      {rst_n, isUpstream, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hF;
      recvUnion = 64'h0000_0000_0000_0007;
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rd(OFF_CAP, 32'h0000_001F, RESP_OKAY);
      wr(OFF_CAP, 32'h0000_003F, RESP_OKAY);
      rd(OFF_CAP, 32'h0000_003F, RESP_OKAY);
      rd(8'h40, 32'h0, RESP_SLVERR);
      wr(8'h30, 32'h1, RESP_SLVERR);
      // all routing fields set before any traffic flows
      wr(OFF_BASE_LO, 32'h0010_000C, RESP_OKAY);
      wr(OFF_BASE_HI, 32'h0000_0001, RESP_OKAY);
      wr(OFF_CTL, 32'h8000_0003, RESP_OKAY);
      for (int g = 0; g < 4; g++) begin
         pkt(PKT_MEMWR, ga(g), 2'h1, 1'b1, 6'(g), 1'b0);
         chk(res.silentDrop, g == 3);
      end
      pkt(PKT_MEMWR, ga(0) + 64'hFBF, 2'h1, 1'b1, 6'h0, 1'b0);
      pkt(PKT_MSG_ADDR, ga(1), 2'h1, 1'b1, 6'h1, 1'b0);
      // source-check failure and poison ride along without changing the verdict
      lastHdr.acsSrcFail = 1'b1;
      lastHdr.poisoned   = 1'b1;
      src.send(lastHdr);
      #1;
      chk(res.acsFail, 1'b1);
      chk(res.isMc, 1'b1);
      chk(res.hdr, lastHdr);
      pkt(PKT_OTHER, ga(1), 2'h1, 1'b0, 6'h0, 1'b0);
      pkt(PKT_MEMWR, ga(4), 2'h1, 1'b0, 6'h0, 1'b0);
      pkt(PKT_MEMWR, ga(1) ^ 64'h1000_0000, 2'h1, 1'b0, 6'h0, 1'b0);
      pkt(PKT_MEMWR, ga(1) ^ 64'h2_0000_0000, 2'h1, 1'b0, 6'h0, 1'b0);
      wr(OFF_BLKALL_LO, 32'h0000_0002, RESP_OKAY);
      pkt(PKT_MEMWR, ga(1), 2'h1, 1'b1, 6'h1, 1'b1);
      chk(aerHdrLog, lastHdr);
      chk({staPrimary, staSecondary}, 2'h1);
      wr(OFF_BLKUT_LO, 32'h0000_0004, RESP_OKAY);
      pkt(PKT_MEMWR, ga(2), 2'h2, 1'b1, 6'h2, 1'b0);
      pkt(PKT_MEMWR, ga(2), AT_UNTRANSLATED, 1'b1, 6'h2, 1'b1);
      @(posedge clk_sys);
      isUpstream <= 1'b1;
      pkt(PKT_MEMWR, ga(1), 2'h1, 1'b1, 6'h1, 1'b1);
      chk({staPrimary, staSecondary}, 2'h3);
      wr(OFF_STATUS, 32'h0000_0003, RESP_OKAY);
      rd(OFF_STATUS, 32'h0, RESP_OKAY);
      rd(OFF_BLK_COUNT, 32'h0000_0003, RESP_OKAY);
      // three groups still need two id bits, so id 3 lies past the enabled range
      wr(OFF_CTL, 32'h8000_0002, RESP_OKAY);
      pkt(PKT_MEMWR, ga(3), 2'h1, 1'b0, 6'h0, 1'b0);
      wr(OFF_CTL, 32'h0000_0003, RESP_OKAY);
      pkt(PKT_MEMWR, ga(0), 2'h1, 1'b0, 6'h0, 1'b0);
      finish_test();
   end
endmodule : multicast_ingress_classifier_bench
